// ---- inc/mpgk_consts.vh ----
`ifndef MPGK_CONSTS_VH
`define MPGK_CONSTS_VH
// register indices, byte address is index * 4
`define MPGK_IDX_B_DIR      6'h00
`define MPGK_IDX_C_DIR      6'h01
`define MPGK_IDX_A_PULL     6'h03
`define MPGK_IDX_B_ATT      6'h04
`define MPGK_IDX_C_ATT      6'h05
`define MPGK_IDX_A_VAL      6'h07
`define MPGK_IDX_B_VAL      6'h08
`define MPGK_IDX_C_VAL      6'h09
`define MPGK_IDX_B_SCAN     6'h1B
`define MPGK_IDX_C_SCAN     6'h1C
`define MPGK_IDX_CTRL       6'h30
`define MPGK_IDX_IRQ_STAT   6'h31
`define MPGK_IDX_IRQ_MASK   6'h32
// widths of implemented fields
`define MPGK_A_MASK         8'h3F
`define MPGK_B_MASK_NARROW  8'h3F
`define MPGK_C_SCAN_MASK    8'h01
`define MPGK_RST_VAL        8'h00
// control register fields
`define MPGK_CTRL_SLEEP     0
`define MPGK_CTRL_TWO_PORT  1
// status bits
`define MPGK_ST_WAKE        0
`define MPGK_ST_CHANGE      1
// scan pulse period and width, in ns
`define MPGK_SCAN_PERIOD_NS 1000
`define MPGK_SCAN_LOW_NS    200
`define MPGK_CLK_NS         8
`endif

// ---- hdl/mpgk_gpio.v ----
// Overview of operation
// - reset leaves ports A to C input, registers zero; port D pin five follows pd5_dir
// - port A six input-only pins
// - A pull enable connects pull resistor
// - A data bit picks pull direction
// - A read returns pin levels
// - four-port: A change in sleep wakes
// - two-port: B input-pin change (bits five to zero) in sleep wakes
// - direction bit one means output
// - input: data selects float or pull
// - output drives data, inverted by attribute
// - port D pin five drives low only
// - port B eight or six pins
// - B/C reads return pin levels
// - port C up to eight pins
// - per-pin key-scan select, two-port variants
// - B scan select bits five to zero
// - C scan select bit zero only
// - scan pin: pull-high, low pulses, wakes
`timescale 1ns/10ps
`include "mpgk_consts.vh"
module mpgk_gpio (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire [5:0]  pa_in,
  output wire [5:0]  pa_pull_en,
  output wire [5:0]  pa_pull_high,
  input  wire [7:0]  pb_in,
  output wire [7:0]  pb_out,
  output wire [7:0]  pb_oe,
  output wire [7:0]  pb_pull_en,
  output wire [7:0]  pb_pull_high,
  input  wire [7:0]  pc_in,
  output wire [7:0]  pc_out,
  output wire [7:0]  pc_oe,
  output wire [7:0]  pc_pull_en,
  output wire [7:0]  pc_pull_high,
  input  wire        pd5_dir,
  input  wire        pd5_att,
  input  wire        pd5_val,
  input  wire        pd5_scan,
  output wire        pd5_out,
  output wire        pd5_oe,
  output wire        pd5_pull_en,
  output wire        pd5_pull_high,
  output wire        wake,
  output wire        irq
);

  localparam [15:0] SCAN_PER = `MPGK_SCAN_PERIOD_NS / `MPGK_CLK_NS;
  localparam [15:0] SCAN_LOW = (`MPGK_SCAN_LOW_NS + `MPGK_CLK_NS - 1) / `MPGK_CLK_NS;

  reg  [7:0]  b_dir_q, c_dir_q, a_pull_q, b_att_q, c_att_q;
  reg  [7:0]  a_val_q, b_val_q, c_val_q, b_scan_q, c_scan_q;
  reg  [1:0]  ctrl_q;
  reg  [1:0]  stat_q;
  reg  [1:0]  mask_q;
  reg         wr_pend_q;
  reg         rd_pend_q;
  reg  [5:0]  idx_q;
  reg  [31:0] rdata_q;
  reg  [21:0] s1_q, s2_q, s3_q;
  reg  [21:0] sync_q;
  reg  [15:0] scan_cnt_q;
  reg  [1:0]  stat_d;

  wire [5:0]  a_pin = sync_q[5:0];
  wire [7:0]  b_pin = sync_q[13:6];
  wire [7:0]  c_pin = sync_q[21:14];
  wire        two_port = ctrl_q[`MPGK_CTRL_TWO_PORT];
  wire        sleep = ctrl_q[`MPGK_CTRL_SLEEP];
  wire [7:0]  b_mask = two_port ? `MPGK_B_MASK_NARROW : 8'hFF;
  wire        scan_low = scan_cnt_q < SCAN_LOW;
  wire        access = hsel & hready & htrans[1];
  wire        addr_ok = (haddr[1:0] == 2'h0) & (haddr[31:8] == 24'h000000);

  // pin encoding shared by ports B and C
  function [3:0] pin_cfg;
    input d, a, v, s, slp;
    reg scan_act;
    begin
      scan_act = s & slp;
      if (scan_act)
        pin_cfg = {1'b0, scan_low, 1'b1, 1'b1};
      else if (d)
        pin_cfg = {a ^ v, 1'b1, 1'b0, 1'b0};
      else
        pin_cfg = {1'b0, 1'b0, v, a & v};
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pin
      wire [3:0] cb = pin_cfg(b_dir_q[g], b_att_q[g], b_val_q[g], b_scan_q[g], sleep);
      wire [3:0] cc = pin_cfg(c_dir_q[g], c_att_q[g], c_val_q[g], c_scan_q[g], sleep);
      assign pb_out[g]       = cb[3];
      assign pb_oe[g]        = cb[2];
      assign pb_pull_en[g]   = cb[1];
      assign pb_pull_high[g] = cb[0];
      assign pc_out[g]       = cc[3];
      assign pc_oe[g]        = cc[2];
      assign pc_pull_en[g]   = cc[1];
      assign pc_pull_high[g] = cc[0];
    end
  endgenerate

  assign pa_pull_en   = a_pull_q[5:0];
  assign pa_pull_high = a_pull_q[5:0] & a_val_q[5:0];

  // open-drain pin: drives low when output and data equals attribute, or during the scan low pulse
  wire pd5_scan_act = pd5_scan & sleep;
  assign pd5_out       = 1'b0;
  assign pd5_oe        = pd5_scan_act ? scan_low : (pd5_dir & (pd5_att == pd5_val));
  assign pd5_pull_en   = pd5_scan_act | (~pd5_dir & pd5_val);
  assign pd5_pull_high = pd5_scan_act | (~pd5_dir & pd5_val & pd5_att);

  // three-stage pin sampling, change counted when stages two and three agree
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 22'h000000;
      s2_q <= 22'h000000;
      s3_q <= 22'h000000;
      sync_q <= 22'h000000;
    end else begin
      s1_q <= {pc_in, pb_in, pa_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
      sync_q <= (s2_q & s3_q) | (sync_q & (s2_q | s3_q));
    end
  end

  // level change detection, wake-up in sleep
  wire [21:0] chg   = (s2_q & s3_q & ~sync_q) | (~s2_q & ~s3_q & sync_q);
  wire        a_chg = |chg[5:0] & ~two_port;
  wire        b_chg = |(chg[13:6] & ~b_dir_q & b_mask) & two_port;
  wire        k_chg = |(chg[13:6] & b_scan_q & b_mask) | (chg[14] & c_scan_q[0]);
  wire        wake_ev = sleep & (a_chg | b_chg | k_chg);
  assign wake = wake_ev;

  // fixed-frequency scan pulse
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      scan_cnt_q <= 16'h0000;
    else if (!sleep || scan_cnt_q >= SCAN_PER - 16'h0001)
      scan_cnt_q <= 16'h0000;
    else
      scan_cnt_q <= scan_cnt_q + 16'h0001;
  end

  // read data, reserved bits zero
  function [7:0] rd_mux;
    input [5:0] i;
    begin
      case (i)
        `MPGK_IDX_B_DIR:    rd_mux = b_dir_q;
        `MPGK_IDX_C_DIR:    rd_mux = c_dir_q;
        `MPGK_IDX_A_PULL:   rd_mux = a_pull_q;
        `MPGK_IDX_B_ATT:    rd_mux = b_att_q;
        `MPGK_IDX_C_ATT:    rd_mux = c_att_q;
        `MPGK_IDX_A_VAL:    rd_mux = {2'b00, a_pin};
        `MPGK_IDX_B_VAL:    rd_mux = b_pin & b_mask;
        `MPGK_IDX_C_VAL:    rd_mux = c_pin;
        `MPGK_IDX_B_SCAN:   rd_mux = b_scan_q;
        `MPGK_IDX_C_SCAN:   rd_mux = c_scan_q;
        `MPGK_IDX_CTRL:     rd_mux = {6'h00, ctrl_q};
        `MPGK_IDX_IRQ_STAT: rd_mux = {6'h00, stat_q};
        `MPGK_IDX_IRQ_MASK: rd_mux = {6'h00, mask_q};
        default:            rd_mux = 8'h00;
      endcase
    end
  endfunction

  wire [7:0] wd = hwdata[7:0];
  wire       stat_rd = access & ~hwrite & addr_ok & (haddr[7:2] == `MPGK_IDX_IRQ_STAT);

  always @* begin
    stat_d = stat_q;
    if (stat_rd)
      stat_d = 2'b00;
    if (wake_ev)
      stat_d[`MPGK_ST_WAKE] = 1'b1;
    if (|chg)
      stat_d[`MPGK_ST_CHANGE] = 1'b1;
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      b_dir_q   <= `MPGK_RST_VAL;
      c_dir_q   <= `MPGK_RST_VAL;
      a_pull_q  <= `MPGK_RST_VAL;
      b_att_q   <= `MPGK_RST_VAL;
      c_att_q   <= `MPGK_RST_VAL;
      a_val_q   <= `MPGK_RST_VAL;
      b_val_q   <= `MPGK_RST_VAL;
      c_val_q   <= `MPGK_RST_VAL;
      b_scan_q  <= `MPGK_RST_VAL;
      c_scan_q  <= `MPGK_RST_VAL;
      ctrl_q    <= 2'b00;
      stat_q    <= 2'b00;
      mask_q    <= 2'b00;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q     <= 6'h00;
      rdata_q   <= 32'h00000000;
    end else begin
      stat_q    <= stat_d;
      wr_pend_q <= access & hwrite & addr_ok;
      rd_pend_q <= access & ~hwrite;
      if (access)
        idx_q <= haddr[7:2];
      if (access & ~hwrite)
        rdata_q <= addr_ok ? {24'h000000, rd_mux(haddr[7:2])} : 32'h00000000;
      if (wr_pend_q) begin
        case (idx_q)
          `MPGK_IDX_B_DIR:    b_dir_q  <= wd & b_mask;
          `MPGK_IDX_C_DIR:    c_dir_q  <= wd;
          `MPGK_IDX_A_PULL:   a_pull_q <= wd & `MPGK_A_MASK;
          `MPGK_IDX_B_ATT:    b_att_q  <= wd & b_mask;
          `MPGK_IDX_C_ATT:    c_att_q  <= wd;
          `MPGK_IDX_A_VAL:    a_val_q  <= wd & `MPGK_A_MASK;
          `MPGK_IDX_B_VAL:    b_val_q  <= wd & b_mask;
          `MPGK_IDX_C_VAL:    c_val_q  <= wd;
          `MPGK_IDX_B_SCAN:   b_scan_q <= two_port ? (wd & `MPGK_B_MASK_NARROW) : 8'h00;
          `MPGK_IDX_C_SCAN:   c_scan_q <= two_port ? (wd & `MPGK_C_SCAN_MASK) : 8'h00;
          `MPGK_IDX_CTRL:     ctrl_q   <= wd[1:0];
          `MPGK_IDX_IRQ_MASK: mask_q   <= wd[1:0];
          default: ;
        endcase
      end
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign irq       = |(stat_q & mask_q);

endmodule

// ---- test/mpgk_board.sv ----
`timescale 1ns/10ps
module mpgk_board #(parameter W = 8) (
  input  wire         clk,
  input  wire [W-1:0] oe,
  input  wire [W-1:0] dout,
  input  wire [W-1:0] pe,
  input  wire [W-1:0] ph,
  input  wire [W-1:0] ken,
  input  wire [W-1:0] kv,
  output wire [W-1:0] lvl
);
  reg [W-1:0] flt_q = 0;
  // an undriven, unpulled pin wanders every cycle
  always @(posedge clk) flt_q <= ~flt_q;
  assign lvl = oe & dout | ~oe & (ken & kv | ~ken & (pe & ph | ~pe & flt_q));
endmodule

// ---- test/mpgk_gpio_checker.sv ----
`timescale 1ns/10ps
module mpgk_gpio_checker (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire [5:0]  pa_pull_en,
  input wire [5:0]  pa_pull_high,
  input wire [7:0]  pc_oe,
  input wire [7:0]  pc_pull_en,
  input wire        pd5_dir,
  input wire        pd5_att,
  input wire        pd5_val,
  input wire        pd5_scan,
  input wire        pd5_out,
  input wire        pd5_oe,
  input wire        pd5_pull_en,
  input wire        pd5_pull_high,
  input wire        irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_reset_all_input: assert property ($rose(hresetn) |-> pc_oe == 0 && pa_pull_en == 0 && !irq)
    else $error("not idle after reset");
  a_pa_pull_dir: assert property ((pa_pull_high & ~pa_pull_en) == 6'h00)
    else $error("pull high without pull");
  a_pa_pull_write: assert property ((hsel && htrans[1] && hwrite && haddr == 32'h0000000C) ##1 1
    |=> pa_pull_en == $past(hwdata[5:0])) else $error("pull enable not stored");
  a_pa_pull_hold: assert property (!(hsel && htrans[1] && hwrite) |-> ##2 $stable(pa_pull_en))
    else $error("pull enable moved");
  a_pc_out_no_pull: assert property ((pc_oe[7:1] & pc_pull_en[7:1]) == 7'h00)
    else $error("output pin pulled");
  a_pd5_low_only: assert property (pd5_out == 1'b0)
    else $error("pin five drives high");
  a_pd5_drive_match: assert property (pd5_dir && !pd5_scan |-> pd5_oe == (pd5_att == pd5_val))
    else $error("pin five drive wrong");
  a_pd5_input_pull: assert property (!pd5_dir && !pd5_scan |-> !pd5_oe && pd5_pull_en == pd5_val
    && pd5_pull_high == (pd5_val && pd5_att)) else $error("pin five pull wrong");
endmodule
bind mpgk_gpio mpgk_gpio_checker chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .pa_pull_en,
  .pa_pull_high, .pc_oe, .pc_pull_en, .pd5_dir, .pd5_att, .pd5_val, .pd5_scan, .pd5_out, .pd5_oe, .pd5_pull_en,
  .pd5_pull_high, .irq);

// ---- test/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  reg         hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, pd5_dir = 0, pd5_att = 0, pd5_val = 0, pd5_scan = 0;
  reg  [1:0]  htrans = 0;
  reg  [2:0]  hsize = 3'h2;
  reg  [31:0] haddr = 0, hwdata = 0, rnd = 32'hB30F;
  reg  [15:0] m;
  reg  [7:0]  r, d [0:7], k [0:5];
  integer     failures = 0, compares = 0, cyc = 0, wakes = 0, i, j;
  wire [31:0] hrdata;
  wire        hreadyout, pd5_out, pd5_oe, pd5_pull_en, pd5_pull_high, wake, irq;
  wire [5:0]  pa_in, pa_pull_en, pa_pull_high;
  wire [7:0]  pb_in, pb_out, pb_oe, pb_pull_en, pb_pull_high, pc_in, pc_out, pc_oe, pc_pull_en, pc_pull_high;
  localparam [63:0] WIX = 64'h00_04_08_01_05_09_03_07;
  localparam [79:0] RIX = 80'h00_01_03_04_05_1B_1C_30_32_20;
  localparam [47:0] TW = 48'h1B_3F_1C_01_00_3F;
  mpgk_gpio uut (.*, .hready(hreadyout), .hresp());
  mpgk_board #(6) pa (.clk(hclk), .oe(6'h00), .dout(6'h00), .pe(pa_pull_en), .ph(pa_pull_high),
    .ken(k[2][5:0]), .kv(k[5][5:0]), .lvl(pa_in));
  mpgk_board pb (.clk(hclk), .oe(pb_oe), .dout(pb_out), .pe(pb_pull_en), .ph(pb_pull_high),
    .ken(k[0]), .kv(k[3]), .lvl(pb_in));
  mpgk_board pc (.clk(hclk), .oe(pc_oe), .dout(pc_out), .pe(pc_pull_en), .ph(pc_pull_high),
    .ken(k[1]), .kv(k[4]), .lvl(pc_in));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // {known bits, expected level} of a port seen from the board
  function [15:0] pin(input [7:0] o, v, pe, ph, en, kv);
    pin = {o | en | pe, o & v | ~o & (en & kv | ~en & ph)};
  endfunction
  task chk(input [31:0] s, e);
    begin
      compares = compares + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("wrong value at %0t: %h vs %h", $time, s, e);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task bus(input w, input [7:0] ix, input [7:0] wd, output [7:0] rd);
    begin
      hsel <= 1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {22'h0, ix, 2'h0};
      @(posedge hclk);
      while (hreadyout !== 1) @(posedge hclk);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      @(posedge hclk);
      while (hreadyout !== 1) @(posedge hclk);
      rd = hrdata[7:0];
    end
  endtask
  task pchk(input [7:0] oe, o, pe, ph, dr, at, v);
    begin
      chk(oe, dr);
      chk(o & dr, (v ^ at) & dr);
      chk(pe, ~dr & v);
      chk(ph, ~dr & v & at);
    end
  endtask
  task vchk(input [7:0] ix, input [15:0] mk);
    begin
      bus(0, ix, 8'h00, r);
      chk(r & mk[15:8], mk[7:0] & mk[15:8]);
    end
  endtask
  always #4 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc = cyc + 1;
    if (wake === 1'b1) wakes = wakes + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      end_of_test;
    end
  end
  initial begin
    for (j = 0; j < 6; j = j + 1) k[j] = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    for (i = 0; i < 10; i = i + 1) begin
      bus(0, RIX[79-8*i -: 8], 8'h00, r);
      chk(r, 0);
    end
    $display("reset test done");
    for (i = 0; i < 16; i = i + 1) begin
      for (j = 0; j < 8; j = j + 1) begin
        rnd = lfsr(rnd);
        d[j] = rnd[7:0];
        if (j < 6) k[j] <= rnd[15:8];
        bus(1, WIX[63-8*j -: 8], d[j], r);
      end
      {pd5_dir, pd5_att, pd5_val, pd5_scan} <= rnd[19:16];
      repeat (6) @(posedge hclk);
      pchk(pb_oe, pb_out, pb_pull_en, pb_pull_high, d[0], d[1], d[2]);
      pchk(pc_oe, pc_out, pc_pull_en, pc_pull_high, d[3], d[4], d[5]);
      chk(pa_pull_en, d[6] & 8'h3F);
      chk(pa_pull_high, d[6] & d[7] & 8'h3F);
      vchk(8'h08, pin(d[0], d[1] ^ d[2], ~d[0] & d[2], d[1], k[0], k[3]));
      vchk(8'h09, pin(d[3], d[4] ^ d[5], ~d[3] & d[5], d[4], k[1], k[4]));
      vchk(8'h07, pin(8'h00, 8'h00, d[6], d[7], k[2], k[5]) & 16'hFF3F | 16'hC000);
    end
    $display("port test done");
    bus(1, 8'h32, 8'h00, r);
    bus(1, 8'h30, 8'h01, r);
    k[2] <= 8'h3F;
    repeat (6) @(posedge hclk);
    bus(0, 8'h31, 8'h00, r);
    k[5] <= ~k[5];
    repeat (10) @(posedge hclk);
    chk(irq, 0);
    bus(1, 8'h32, 8'h01, r);
    @(posedge hclk);
    chk(irq, 1);
    bus(0, 8'h31, 8'h00, r);
    chk(r[0], 1);
    bus(0, 8'h31, 8'h00, r);
    @(posedge hclk);
    chk(r[0], 0);
    chk(irq, 0);
    bus(1, 8'h30, 8'h03, r);
    for (i = 0; i < 3; i = i + 1) begin
      bus(1, TW[47-16*i -: 8], 8'hFF, r);
      bus(0, TW[47-16*i -: 8], 8'h00, r);
      chk(r, TW[39-16*i -: 8]);
    end
    for (i = 0; i < 4; i = i + 1) bus(1, WIX[63-8*i -: 8], {8{i[1]}}, r);
    bus(1, 8'h1B, 8'h00, r);
    k[0] <= 8'h20;
    repeat (6) @(posedge hclk);
    bus(0, 8'h31, 8'h00, r);
    k[3] <= ~k[3];
    for (j = 0; j < 20 && irq !== 1; j = j + 1) @(posedge hclk);
    chk(irq, 1);
    chk(wakes != 0, 1);
    bus(1, 8'h1B, 8'h01, r);
    for (j = 0; j < 200 && (pb_oe[0] & ~pb_out[0]) !== 1; j = j + 1) @(posedge hclk);
    chk(pb_oe[0] & ~pb_out[0], 1);
    $display("sleep test done");
    end_of_test;
  end
endmodule
